// ### src/usbemr_responder.sv
// Purpose: endpoint handshake selection and automatic mode rewrites
// Assumes: token reports and host ACK come from logic on MCLK_I
// Notes: registers reached over Avalon-MM with waitrequest
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - each endpoint's 4-bit mode field picks its handshakes, same coding
// - mode 0000 ignores every SETUP, IN and OUT token
// - mode 0001 ACKs valid SETUP, NAKs every IN and every valid OUT
// - control endpoint: ACKed SETUP forces mode to 0001 unless mode is 0000
// - 1011 accepts SETUP, NAKs IN, ACKs OUT then becomes 0001
// - 1001 ignores SETUP and IN; OUT gets ACK, or STALL if stall bit set
// - 1000 ignores SETUP and IN, NAKs OUT; entered after ACKed OUT in 1001
// - 1101 ignores SETUP/OUT; IN sends count or STALL; host ACK gives 1100
// - 1100 ignores SETUP and OUT and NAKs IN
// - 1111 accepts SETUP, IN sends count, OUT checked; host ACK gives 1110
// - 1110 accepts SETUP, NAKs IN, status-checks OUT
// - 0010 STALL IN check OUT; 0110 zero IN STALL OUT; 1010 zero IN NAK OUT
// - 0011 STALLs IN and OUT; 0100 ignores IN and OUT; both accept SETUP
// - status check ACKs only zero-length toggle-1 OUT, else STALL or ignore
// - counted payload length is the endpoint's 4-bit byte count field
// - all modes reset to 0000 and stay there until firmware writes
module usbemr_responder
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // avalon-mm slave
  input wire logic [usbemr_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // token side of the protocol engine
  input wire logic TOKEN_VALID_I,
  input wire usbemr_pkg::usbemr_tok_t TOKEN_I,
  input wire logic HOST_ACK_I,
  output logic ANSWER_VALID_O,
  output usbemr_pkg::usbemr_ans_t ANSWER_O
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [3:0] mode_q [usbemr_pkg::NUM_EP];
  logic stall_q [usbemr_pkg::NUM_EP];
  logic [3:0] cnt_q [usbemr_pkg::NUM_EP];
  logic wait_q;
  logic [31:0] rdata_q;
  logic ans_valid_q;
  usbemr_pkg::usbemr_ans_t ans_q;
  logic pend_q;
  logic [1:0] pend_ep_q;
  usbemr_pkg::usbemr_ans_t last_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then waitrequest low for one edge
  logic req;
  logic wr_take;
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign wr_take = AVS_WRITE_I & ~wait_q & AVS_BYTEENABLE_I[0];

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      wait_q <= 1'b1;
    else
      wait_q <= ~(req & wait_q);
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_q <= 32'h0000_0000;
    else if (AVS_READ_I & wait_q)
    begin
      unique case (AVS_ADDRESS_I)
        usbemr_pkg::OFS_MODE0: rdata_q <= {28'h000_0000, mode_q[0]};
        usbemr_pkg::OFS_MODE1:
          rdata_q <= {24'h00_0000, stall_q[1], 3'h0, mode_q[1]};
        usbemr_pkg::OFS_MODE2:
          rdata_q <= {24'h00_0000, stall_q[2], 3'h0, mode_q[2]};
        usbemr_pkg::OFS_CNT0: rdata_q <= {28'h000_0000, cnt_q[0]};
        usbemr_pkg::OFS_CNT1: rdata_q <= {28'h000_0000, cnt_q[1]};
        usbemr_pkg::OFS_CNT2: rdata_q <= {28'h000_0000, cnt_q[2]};
        usbemr_pkg::OFS_STAT: rdata_q <= {25'h000_0000, last_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign AVS_WAITREQUEST_O = wait_q;
  assign AVS_READDATA_O = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // response decode for the addressed endpoint
  logic [1:0] ep;
  logic ep_ok;
  logic [3:0] cur_mode;
  logic cur_stall;
  logic [3:0] cur_cnt;
  usbemr_pkg::usbemr_rsp_t rsp;
  logic check_ok;

  assign ep = TOKEN_I.ep;
  assign ep_ok = (ep != 2'h3);
  assign cur_mode = ep_ok ? mode_q[ep] : usbemr_pkg::M_DISABLE;
  assign cur_stall = ep_ok ? stall_q[ep] : 1'b0;
  assign cur_cnt = ep_ok ? cnt_q[ep] : 4'h0;
  assign check_ok = TOKEN_I.zero_len & TOKEN_I.toggle;

  always_comb
  begin
    rsp = usbemr_pkg::RSP_IGNORE;
    unique case (TOKEN_I.pid)
      usbemr_pkg::PID_SETUP:
      begin
        unique case (cur_mode)
          usbemr_pkg::M_NAK_IO, usbemr_pkg::M_STAT_OUT,
          usbemr_pkg::M_STALL_IO, usbemr_pkg::M_IGN_IO,
          usbemr_pkg::M_STAT_IN, usbemr_pkg::M_NAKO_STI,
          usbemr_pkg::M_ACKO_NAKI, usbemr_pkg::M_NAKI_STO,
          usbemr_pkg::M_ACKI_STO:
            rsp = usbemr_pkg::RSP_ACK;
          default:
            rsp = usbemr_pkg::RSP_IGNORE;
        endcase
      end
      usbemr_pkg::PID_IN:
      begin
        unique case (cur_mode)
          usbemr_pkg::M_NAK_IO, usbemr_pkg::M_ACKO_NAKI,
          usbemr_pkg::M_NAK_IN, usbemr_pkg::M_NAKI_STO:
            rsp = usbemr_pkg::RSP_NAK;
          usbemr_pkg::M_STAT_OUT, usbemr_pkg::M_STALL_IO:
            rsp = usbemr_pkg::RSP_STALL;
          usbemr_pkg::M_STAT_IN, usbemr_pkg::M_NAKO_STI:
            rsp = usbemr_pkg::RSP_TX_ZERO;
          usbemr_pkg::M_ACK_IN:
            rsp = cur_stall ? usbemr_pkg::RSP_STALL
                            : usbemr_pkg::RSP_TX_COUNT;
          usbemr_pkg::M_ACKI_STO, usbemr_pkg::M_RSV7:
            rsp = usbemr_pkg::RSP_TX_COUNT;
          default:
            rsp = usbemr_pkg::RSP_IGNORE;
        endcase
      end
      usbemr_pkg::PID_OUT:
      begin
        unique case (cur_mode)
          usbemr_pkg::M_NAK_IO, usbemr_pkg::M_NAK_OUT,
          usbemr_pkg::M_NAKO_STI:
            rsp = usbemr_pkg::RSP_NAK;
          usbemr_pkg::M_STALL_IO, usbemr_pkg::M_STAT_IN:
            rsp = usbemr_pkg::RSP_STALL;
          usbemr_pkg::M_ACK_OUT:
            rsp = cur_stall ? usbemr_pkg::RSP_STALL
                            : usbemr_pkg::RSP_ACK;
          usbemr_pkg::M_ACKO_NAKI, usbemr_pkg::M_RSV5:
            rsp = usbemr_pkg::RSP_ACK;
          usbemr_pkg::M_STAT_OUT, usbemr_pkg::M_NAKI_STO,
          usbemr_pkg::M_ACKI_STO:
            rsp = check_ok ? usbemr_pkg::RSP_ACK
                           : usbemr_pkg::RSP_STALL;
          default:
            rsp = usbemr_pkg::RSP_IGNORE;
        endcase
      end
      default:
        rsp = usbemr_pkg::RSP_IGNORE;
    endcase
    // corrupt data phases get no handshake at all
    if (TOKEN_I.pid != usbemr_pkg::PID_IN && !TOKEN_I.data_ok)
      rsp = usbemr_pkg::RSP_IGNORE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer to the engine
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ans_valid_q <= 1'b0;
      ans_q <= '{rsp: usbemr_pkg::RSP_IGNORE, count: 4'h0};
    end
    else
    begin
      ans_valid_q <= TOKEN_VALID_I;
      if (TOKEN_VALID_I)
      begin
        ans_q.rsp <= rsp;
        ans_q.count <= (rsp == usbemr_pkg::RSP_TX_COUNT) ? cur_cnt
                                                         : 4'h0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      last_q <= '{rsp: usbemr_pkg::RSP_IGNORE, count: 4'h0};
    else if (TOKEN_VALID_I)
      last_q <= '{rsp: rsp, count: {2'h0, ep}};
  end

  assign ANSWER_VALID_O = ans_valid_q;
  assign ANSWER_O = ans_q;

  ////////////////////////////////////////////////////////////////////////////
  // counted IN awaiting the host ACK
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pend_q <= 1'b0;
      pend_ep_q <= 2'h0;
    end
    else if (TOKEN_VALID_I)
    begin
      pend_q <= (TOKEN_I.pid == usbemr_pkg::PID_IN) &&
                (rsp == usbemr_pkg::RSP_TX_COUNT);
      pend_ep_q <= ep;
    end
    else if (HOST_ACK_I)
      pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-endpoint registers; engine rewrites win over firmware writes
  for (genvar i = 0; i < usbemr_pkg::NUM_EP; i++)
  begin : g_ep
    localparam logic [4:0] OFS_M = usbemr_pkg::OFS_MODE0 + 5'(4 * i);
    localparam logic [4:0] OFS_C = usbemr_pkg::OFS_CNT0 + 5'(4 * i);
    logic hit;
    logic ack_now;
    logic host_ack;
    logic setup_ack;
    logic out_ack;
    logic mode_wr;
    logic cnt_wr;
    logic [3:0] mode_d;
    assign hit = TOKEN_VALID_I && ep_ok && (ep == 2'(i));
    assign ack_now = hit && (rsp == usbemr_pkg::RSP_ACK);
    assign host_ack = HOST_ACK_I && pend_q && (pend_ep_q == 2'(i));
    assign setup_ack = ack_now && (TOKEN_I.pid == usbemr_pkg::PID_SETUP);
    assign out_ack = ack_now && (TOKEN_I.pid == usbemr_pkg::PID_OUT);
    assign mode_wr = wr_take && (AVS_ADDRESS_I == OFS_M);
    assign cnt_wr = wr_take && (AVS_ADDRESS_I == OFS_C);

    // next mode; an engine rewrite beats a firmware write in the same cycle
    always_comb
    begin
      mode_d = mode_q[i];
      if (setup_ack && (i == 0) && (mode_q[i] != usbemr_pkg::M_DISABLE))
        mode_d = usbemr_pkg::M_NAK_IO;
      else if (out_ack && (mode_q[i] == usbemr_pkg::M_ACKO_NAKI))
        mode_d = usbemr_pkg::M_NAK_IO;
      else if (out_ack && (mode_q[i] == usbemr_pkg::M_ACK_OUT))
        mode_d = usbemr_pkg::M_NAK_OUT;
      else if (out_ack && (mode_q[i] == usbemr_pkg::M_ACKI_STO))
        mode_d = usbemr_pkg::M_NAKI_STO;
      else if (host_ack && (mode_q[i] == usbemr_pkg::M_ACK_IN))
        mode_d = usbemr_pkg::M_NAK_IN;
      else if (host_ack && (mode_q[i] == usbemr_pkg::M_ACKI_STO))
        mode_d = usbemr_pkg::M_NAKI_STO;
      else if (mode_wr)
        mode_d = AVS_WRITEDATA_I[3:0];
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        mode_q[i] <= usbemr_pkg::MODE_RST;
      else
        mode_q[i] <= mode_d;
    end

    // the control endpoint has no stall bit
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        stall_q[i] <= 1'b0;
      else if ((i != 0) && mode_wr)
        stall_q[i] <= AVS_WRITEDATA_I[usbemr_pkg::STALL_BIT];
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        cnt_q[i] <= usbemr_pkg::CNT_RST;
      else if (cnt_wr)
        cnt_q[i] <= AVS_WRITEDATA_I[3:0];
    end
  end

endmodule // usbemr_responder

// ### src/usbemr_pkg.sv
// Purpose: shared constants and types of the endpoint mode responder
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes: mode codes are the 4-bit endpoint mode field values
package usbemr_pkg;
  localparam int NUM_EP = 3;
  localparam int ADDR_W = 5;
  // register byte offsets
  localparam logic [4:0] OFS_MODE0 = 5'h00;
  localparam logic [4:0] OFS_MODE1 = 5'h04;
  localparam logic [4:0] OFS_MODE2 = 5'h08;
  localparam logic [4:0] OFS_CNT0 = 5'h0C;
  localparam logic [4:0] OFS_CNT1 = 5'h10;
  localparam logic [4:0] OFS_CNT2 = 5'h14;
  localparam logic [4:0] OFS_STAT = 5'h18;
  // field positions
  localparam int STALL_BIT = 7;
  // reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] CNT_RST = 4'h0;
  // mode encodings
  localparam logic [3:0] M_DISABLE = 4'h0;
  localparam logic [3:0] M_NAK_IO = 4'h1;
  localparam logic [3:0] M_STAT_OUT = 4'h2;
  localparam logic [3:0] M_STALL_IO = 4'h3;
  localparam logic [3:0] M_IGN_IO = 4'h4;
  localparam logic [3:0] M_RSV5 = 4'h5;
  localparam logic [3:0] M_STAT_IN = 4'h6;
  localparam logic [3:0] M_RSV7 = 4'h7;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAKO_STI = 4'hA;
  localparam logic [3:0] M_ACKO_NAKI = 4'hB;
  localparam logic [3:0] M_NAK_IN = 4'hC;
  localparam logic [3:0] M_ACK_IN = 4'hD;
  localparam logic [3:0] M_NAKI_STO = 4'hE;
  localparam logic [3:0] M_ACKI_STO = 4'hF;

  typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT, PID_NONE} usbemr_pid_t;

  typedef enum logic [2:0] {
    RSP_IGNORE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_TX_COUNT, RSP_TX_ZERO
  } usbemr_rsp_t;

  // token report from the protocol engine
  typedef struct packed {
    usbemr_pid_t pid;
    logic [1:0] ep;
    logic data_ok;
    logic zero_len;
    logic toggle;
  } usbemr_tok_t;

  // answer to the protocol engine
  typedef struct packed {
    usbemr_rsp_t rsp;
    logic [3:0] count;
  } usbemr_ans_t;
endpackage

// ### tb/usbemr_props.sv
// Purpose: port checker for the endpoint mode responder
// Assumes: one clock domain, reset active low
// Notes: bound to the responder after the module
`timescale 1ns/1ps
module usbemr_props
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // register bus
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // token side
  input wire logic TOKEN_VALID_I,
  input wire usbemr_pkg::usbemr_tok_t TOKEN_I,
  input wire logic ANSWER_VALID_O,
  input wire usbemr_pkg::usbemr_ans_t ANSWER_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  ans_latency_a: assert property (TOKEN_VALID_I |=> ANSWER_VALID_O)
    else $error("answer missing after token");
  ans_cause_a: assert property
    (ANSWER_VALID_O |-> $past(TOKEN_VALID_I))
    else $error("answer without token");
  ans_hold_a: assert property (!TOKEN_VALID_I |=> $stable(ANSWER_O))
    else $error("answer changed without token");
  bad_ep_a: assert property (TOKEN_VALID_I && TOKEN_I.ep == 2'h3
    |=> ANSWER_O.rsp == usbemr_pkg::RSP_IGNORE) else $error("bad ep answered");
  bad_data_a: assert property (TOKEN_VALID_I && !TOKEN_I.data_ok
    && TOKEN_I.pid != usbemr_pkg::PID_IN
    |=> ANSWER_O.rsp == usbemr_pkg::RSP_IGNORE)
    else $error("bad data answered");
  count_zero_a: assert property (ANSWER_VALID_O
    && ANSWER_O.rsp != usbemr_pkg::RSP_TX_COUNT |-> ANSWER_O.count == 4'h0)
    else $error("count without payload");
  wait_one_a: assert property ((AVS_READ_I || AVS_WRITE_I)
    && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus wait too long");
  wait_pulse_a: assert property
    (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");

  cover property (ANSWER_VALID_O && ANSWER_O.rsp == usbemr_pkg::RSP_TX_COUNT);
  cover property (ANSWER_VALID_O && ANSWER_O.rsp == usbemr_pkg::RSP_STALL);
  cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
endmodule // usbemr_props

bind usbemr_responder usbemr_props u_props (.MCLK_I(MCLK_I),
  .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .TOKEN_VALID_I(TOKEN_VALID_I),
  .TOKEN_I(TOKEN_I), .ANSWER_VALID_O(ANSWER_VALID_O), .ANSWER_O(ANSWER_O));

// ### tb/usbemr_host.sv
// Purpose: host side model issuing tokens and host acks
// Assumes: driven from the bench clock
// Notes: token lines hold the inverted last token while idle
`timescale 1ns/1ps
module usbemr_host
(
  input wire logic clk_i,
  output logic tok_valid_o,
  output usbemr_pkg::usbemr_tok_t tok_o,
  output logic ack_o
);
  initial
  begin
    tok_valid_o = 1'b0;
    tok_o = '0;
    ack_o = 1'b0;
  end
  // d is data_ok, zero_len, toggle
  task automatic send(input usbemr_pkg::usbemr_pid_t p, input logic [1:0] ep,
    input logic [2:0] d);
    @(posedge clk_i);
    tok_valid_o <= 1'b1;
    tok_o <= {p, ep, d};
    @(posedge clk_i);
    tok_valid_o <= 1'b0;
    tok_o <= ~{p, ep, d};
  endtask
  task automatic host_ack();
    @(posedge clk_i);
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
  endtask
endmodule // usbemr_host

// ### tb/tb.sv
// Purpose: self-checking bench of the endpoint mode responder
// Assumes: one wait cycle on the register bus
// Notes: mode table entries are setup, in, out answer codes
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst_n;
  logic [4:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdo;
  logic [31:0] rdat;
  logic wreq;
  logic tok_v;
  usbemr_pkg::usbemr_tok_t tok;
  logic ack;
  logic ans_v;
  usbemr_pkg::usbemr_ans_t ans;
  int error_cnt = 0;
  int checks = 0;
  logic [11:0] tbl [16] = '{12'h000, 12'h122, 12'h131, 12'h133, 12'h100,
    12'h000, 12'h153, 12'h000, 12'h002, 12'h001, 12'h152, 12'h121, 12'h020,
    12'h040, 12'h121, 12'h141};

  usbemr_responder u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdo), .AVS_WAITREQUEST_O(wreq),
    .TOKEN_VALID_I(tok_v), .TOKEN_I(tok), .HOST_ACK_I(ack),
    .ANSWER_VALID_O(ans_v), .ANSWER_O(ans));
  usbemr_host u_host (.clk_i(clk), .tok_valid_o(tok_v), .tok_o(tok),
    .ack_o(ack));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(n, 2);
  endtask

  task automatic tk(input usbemr_pkg::usbemr_pid_t p, input logic [1:0] ep,
    input logic [2:0] d, input logic [6:0] e);
    u_host.send(p, ep, d);
    #1;
    chk(ans_v, 1);
    chk(ans, e);
  endtask

  task automatic rw(input logic [4:0] a, input logic [3:0] m,
    input usbemr_pkg::usbemr_pid_t p, input logic [6:0] e, input logic ha,
    input logic [3:0] em);
    bus(1'b1, a, 32'(m));
    tk(p, a[3:2], 3'h7, e);
    if (ha)
      u_host.host_ack();
    bus(1'b0, a, 32'h0);
    chk(rdat[3:0], em);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk(rdat, 32'h0);
    end
    rw(5'h00, 4'h0, usbemr_pkg::PID_SETUP, 7'h00, 1'b0, 4'h0);
  endtask

  task automatic t_table();
    logic [3:0] n;
    bus(1'b1, 5'h10, 32'h5);
    for (int m = 0; m < 16; m++)
    begin
      if (m == 5 || m == 7)
        continue;
      for (int p = 0; p < 3; p++)
      begin
        n = tbl[m][11 - 4 * p -: 4];
        bus(1'b1, 5'h04, 32'(m));
        tk(usbemr_pkg::usbemr_pid_t'(p), 2'h1, 3'h7,
          {n[2:0], ((n == 4'h4) ? 4'h5 : 4'h0)});
      end
    end
    bus(1'b1, 5'h04, 32'h89);
    tk(usbemr_pkg::PID_OUT, 2'h1, 3'h7, 7'h30);
    bus(1'b0, 5'h04, 32'h0);
    chk(rdat, 32'h89);
    bus(1'b1, 5'h04, 32'h8D);
    tk(usbemr_pkg::PID_IN, 2'h1, 3'h7, 7'h30);
  endtask

  task automatic t_rewrite();
    rw(5'h00, 4'hB, usbemr_pkg::PID_SETUP, 7'h10, 1'b0, 4'h1);
    rw(5'h04, 4'hB, usbemr_pkg::PID_OUT, 7'h10, 1'b0, 4'h1);
    rw(5'h04, 4'h9, usbemr_pkg::PID_OUT, 7'h10, 1'b0, 4'h8);
    bus(1'b1, 5'h14, 32'hF);
    rw(5'h08, 4'hD, usbemr_pkg::PID_IN, 7'h4F, 1'b1, 4'hC);
    rw(5'h04, 4'hF, usbemr_pkg::PID_IN, 7'h45, 1'b1, 4'hE);
  endtask

  task automatic t_check();
    bus(1'b1, 5'h00, 32'h2);
    tk(usbemr_pkg::PID_OUT, 2'h0, 3'h6, 7'h30);
    tk(usbemr_pkg::PID_OUT, 2'h0, 3'h5, 7'h30);
    tk(usbemr_pkg::PID_OUT, 2'h0, 3'h3, 7'h00);
    tk(usbemr_pkg::PID_IN, 2'h3, 3'h7, 7'h00);
    bus(1'b0, 5'h18, 32'h0);
    chk(rdat, 32'h03);
  endtask

  task automatic t_rerst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(wreq, 1'b1);
    chk(ans_v, 1'b0);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk(rdat, 32'h0);
    end
    tk(usbemr_pkg::PID_SETUP, 2'h0, 3'h7, 7'h00);
  endtask

  initial
  begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wdat = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_table();
    t_rewrite();
    t_check();
    t_rerst();
    wrap_up();
  end

  initial
  begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb
